// ===== hw/sieb_map.svh
// register offsets, interrupt count, field widths and response codes of the status and enable bank
`ifndef SIEB_MAP_SVH
`define SIEB_MAP_SVH
`define SIEB_RAW_SET_G1 8'h00
`define SIEB_RAW_SET_G2 8'h04
`define SIEB_RAW_SET_G3 8'h08
`define SIEB_RAW_SET_G4 8'h0c
`define SIEB_STS_CLR_G1 8'h10
`define SIEB_STS_CLR_G2 8'h14
`define SIEB_STS_CLR_G3 8'h18
`define SIEB_STS_CLR_G4 8'h1c
`define SIEB_ENA_SET_G1 8'h20
`define SIEB_ENA_SET_G2 8'h24
`define SIEB_ENA_SET_G3 8'h28
`define SIEB_ENA_SET_G4 8'h2c
`define SIEB_ENA_CLR_G1 8'h30
`define SIEB_ENA_CLR_G2 8'h34
`define SIEB_ENA_CLR_G3 8'h38
`define SIEB_ENA_CLR_G4 8'h3c
`define SIEB_IRQ_STAT 8'h40
`define SIEB_IRQ_MASK 8'h44
`define SIEB_NUM_IRQ 101
`define SIEB_PAD_BITS 27
`define SIEB_EVT_BITS 4
`define SIEB_RESP_OKAY 2'b00
`define SIEB_RESP_SLVERR 2'b10
`endif

// ===== hw/sieb_pkg.sv
// types of the system interrupt status and enable bank
package sieb_pkg;
    typedef enum logic [1:0] {
        SIEB_KIND_RAW = 2'b00,
        SIEB_KIND_STS = 2'b01,
        SIEB_KIND_ESET = 2'b10,
        SIEB_KIND_ECLR = 2'b11
    } sieb_kind_type;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } sieb_rd_type;
endpackage

// ===== hw/sieb_bank.sv
// system interrupt status and enable bank with an axi4-lite register slave
//
// Behaviour
// - reading a raw/set register returns raw pending bits regardless of enables
// - writing one to a raw/set bit sets that pending status like hardware
// - zero bits written to any set or clear port change nothing
// - reading a status/clear register returns pending status before the enable mask
// - writing one to a status/clear bit clears that pending status
// - writing one to an enable-set bit sets that interrupt's enable
// - writing one to an enable-clear bit clears that interrupt's enable
// - enable-set and enable-clear reads both return the shared enable mask
// - only enabled pending interrupts reach pending_masked_bits; irq_out follows the masked events, where event 0 is any hw trigger
// - one status and enable bit each; group four upper bits read zero
// - group k bit n maps to interrupt n plus 32 times k minus 32
// - all status and enable bits are zero after reset
// - hardware trigger inputs also set raw pending status
`timescale 1ns/10ps
`include "sieb_map.svh"

module sieb_bank #(
    parameter int NUM_IRQ = `SIEB_NUM_IRQ
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [NUM_IRQ-1:0] hw_trigger,
    output logic [NUM_IRQ-1:0] pending_masked_bits,
    output logic irq_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import sieb_pkg::*;

    localparam int PADDED = 128;

    // =====================================================================
    // state
    // =====================================================================
    logic [NUM_IRQ-1:0] raw_status_r;
    logic [NUM_IRQ-1:0] raw_status_nxt;
    logic [NUM_IRQ-1:0] enable_r;
    logic [NUM_IRQ-1:0] enable_nxt;
    logic [`SIEB_EVT_BITS-1:0] evt_stat_r;
    logic [`SIEB_EVT_BITS-1:0] evt_stat_nxt;
    logic [`SIEB_EVT_BITS-1:0] evt_mask_r;
    logic [`SIEB_EVT_BITS-1:0] evt_mask_nxt;
    logic [7:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_have_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    sieb_rd_type rd_r;

    // =====================================================================
    // helpers
    // =====================================================================
    // spreads a 32-bit group word onto the padded interrupt vector
    function automatic logic [PADDED-1:0] place(input logic [31:0] w, input logic [1:0] g);
        logic [PADDED-1:0] v;
        v = '0;
        v[g*32 +: 32] = w;
        return v;
    endfunction

    // byte-lane masked write data
    function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = d;
        for (int i = 0; i < 4; i++) begin
            if (!s[i]) begin
                m[i*8 +: 8] = 8'h00;
            end
        end
        return m;
    endfunction

    // =====================================================================
    // write channel
    // =====================================================================
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [7:0] wr_addr = aw_have_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_have_r ? w_data_r : s_axi_wdata;
    wire [3:0] wr_strb = w_have_r ? w_strb_r : s_axi_wstrb;
    wire aw_ok = aw_have_r || aw_take;
    wire w_ok = w_have_r || w_take;
    wire wr_fire = aw_ok && w_ok && !bvalid_r;
    wire [31:0] wr_word = lane_mask(wr_data, wr_strb);
    wire wr_aligned = (wr_addr[1:0] == 2'b00);
    wire wr_bank = wr_aligned && (wr_addr < `SIEB_IRQ_STAT);
    wire sieb_kind_type wr_kind = sieb_kind_type'(wr_addr[5:4]);
    wire [1:0] wr_group = wr_addr[3:2];
    wire [PADDED-1:0] wr_vec = place(wr_word, wr_group);
    wire wr_stat = wr_fire && wr_aligned && (wr_addr == `SIEB_IRQ_STAT);
    wire wr_mask = wr_fire && wr_aligned && (wr_addr == `SIEB_IRQ_MASK);
    wire wr_known = wr_bank || wr_stat || wr_mask || (wr_addr == `SIEB_IRQ_MASK);

    // readies drop while frozen so the master never sees an address or write-data handshake the state ignores
    assign s_axi_awready = clk_en && !aw_have_r && !bvalid_r;
    assign s_axi_wready = clk_en && !w_have_r && !bvalid_r;

    // zero bits in the vectors below leave state untouched
    wire [NUM_IRQ-1:0] sw_set =
        (wr_fire && wr_bank && wr_kind == SIEB_KIND_RAW) ? wr_vec[NUM_IRQ-1:0] : '0;
    wire [NUM_IRQ-1:0] sw_clr =
        (wr_fire && wr_bank && wr_kind == SIEB_KIND_STS) ? wr_vec[NUM_IRQ-1:0] : '0;
    wire [NUM_IRQ-1:0] en_set =
        (wr_fire && wr_bank && wr_kind == SIEB_KIND_ESET) ? wr_vec[NUM_IRQ-1:0] : '0;
    wire [NUM_IRQ-1:0] en_clr =
        (wr_fire && wr_bank && wr_kind == SIEB_KIND_ECLR) ? wr_vec[NUM_IRQ-1:0] : '0;

    // set terms are applied after clear so a same-cycle trigger survives
    assign raw_status_nxt = (raw_status_r & ~sw_clr) | hw_trigger | sw_set;
    assign enable_nxt = (enable_r & ~en_clr) | en_set;

    // =====================================================================
    // bank events and interrupt
    // =====================================================================
    assign pending_masked_bits = raw_status_r & enable_r;
    // events: 0 hw trigger seen, 1 enabled pending, 2 bad write, 3 bad read
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_bad;
    wire [`SIEB_EVT_BITS-1:0] evt_now = {ar_take && rd_bad,
                                         wr_fire && !wr_known,
                                         |pending_masked_bits,
                                         |hw_trigger};
    wire [`SIEB_EVT_BITS-1:0] evt_clr = wr_stat ? wr_word[`SIEB_EVT_BITS-1:0] : '0;
    assign evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_now;
    assign evt_mask_nxt = wr_mask ? wr_word[`SIEB_EVT_BITS-1:0] : evt_mask_r;
    assign irq_out = |(evt_stat_r & evt_mask_r);

    // =====================================================================
    // read channel
    // =====================================================================
    wire [PADDED-1:0] raw_pad = {{`SIEB_PAD_BITS{1'b0}}, raw_status_r};
    wire [PADDED-1:0] ena_pad = {{`SIEB_PAD_BITS{1'b0}}, enable_r};
    wire [1:0] rd_group = s_axi_araddr[3:2];
    wire rd_aligned = (s_axi_araddr[1:0] == 2'b00);
    wire rd_bank = rd_aligned && (s_axi_araddr < `SIEB_IRQ_STAT);
    wire [31:0] rd_status = raw_pad[rd_group*32 +: 32];
    wire [31:0] rd_enable = ena_pad[rd_group*32 +: 32];
    wire rd_is_stat = rd_aligned && (s_axi_araddr == `SIEB_IRQ_STAT);
    wire rd_is_mask = rd_aligned && (s_axi_araddr == `SIEB_IRQ_MASK);
    assign rd_bad = !(rd_bank || rd_is_stat || rd_is_mask);
    wire [31:0] rd_word =
        rd_bank ? (s_axi_araddr[5] ? rd_enable : rd_status) :
        rd_is_stat ? {28'h0000000, evt_stat_r} :
        rd_is_mask ? {28'h0000000, evt_mask_r} : 32'h00000000;

    assign s_axi_arready = clk_en && !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rd_r.data;
    assign s_axi_rresp = rd_r.resp;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // =====================================================================
    // registers
    // =====================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_status_r <= '0;
            enable_r <= '0;
            evt_stat_r <= '0;
            evt_mask_r <= '0;
        end else if (clk_en) begin
            raw_status_r <= raw_status_nxt;
            enable_r <= enable_nxt;
            evt_stat_r <= evt_stat_nxt;
            evt_mask_r <= evt_mask_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_have_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `SIEB_RESP_OKAY;
        end else if (clk_en) begin
            if (aw_take && !wr_fire) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_r <= 1'b0;
            end
            if (w_take && !wr_fire) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_r <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? `SIEB_RESP_OKAY : `SIEB_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rd_r <= '0;
        end else if (clk_en) begin
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rd_r.data <= rd_word;
                rd_r.resp <= rd_bad ? `SIEB_RESP_SLVERR : `SIEB_RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end
endmodule

// ===== verif/sieb_src_model.sv
// peripheral interrupt sources that drive the hardware trigger lines
`timescale 1ns/10ps
module sieb_src_model #(
    parameter int NUM_IRQ = 101
) (
    input wire logic aclk,
    input wire logic [NUM_IRQ-1:0] req,
    output logic [NUM_IRQ-1:0] hw_trigger = '0
);
    // a source raises its level just after an edge and holds it
    always @(posedge aclk) hw_trigger <= req;
endmodule

// ===== verif/sieb_bank_asserts.sv
// assertions on the ports of the status and enable bank
`timescale 1ns/10ps
module sieb_bank_asserts #(
    parameter int NUM_IRQ = 101
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [NUM_IRQ-1:0] hw_trigger,
    input wire logic [NUM_IRQ-1:0] pending_masked_bits
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // no write can complete while both write channels are idle
    wire logic idle = !s_axi_awvalid && !s_axi_wvalid;
    wire logic [NUM_IRQ-1:0] pm = pending_masked_bits;
    property p_rd_answer; clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_hold;
        s_axi_rvalid && !(clk_en && s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    property p_rd_once; clk_en && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rd_once: assert property (p_rd_once) else $error("read answer repeated");
    property p_wr_hold; s_axi_bvalid && !(clk_en && s_axi_bready) |=> s_axi_bvalid; endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
    property p_wr_once; clk_en && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_wr_once: assert property (p_wr_once) else $error("write response repeated");
    property p_keep; idle |=> (pm & $past(pm)) == $past(pm); endproperty
    a_keep: assert property (p_keep) else $error("pending bit lost without a write");
    property p_rise; idle |=> (pm & ~$past(pm) & ~$past(hw_trigger)) == '0; endproperty
    a_rise: assert property (p_rise) else $error("pending bit rose without cause");
    property p_freeze; !clk_en |=> $stable(pm); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule
bind sieb_bank sieb_bank_asserts #(.NUM_IRQ(NUM_IRQ)) u_asserts (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .hw_trigger(hw_trigger),
    .pending_masked_bits(pending_masked_bits)
);

// ===== verif/sys_irq_status_enable_bank_bench.sv
// self-checking bench of the status and enable bank
`timescale 1ns/10ps
`include "sieb_map.svh"
module sys_irq_status_enable_bank_bench;
    import sieb_pkg::*;
    localparam int N = `SIEB_NUM_IRQ;
    localparam logic [1:0] OK = `SIEB_RESP_OKAY;
    logic aclk = 0, aresetn = 0, clk_en = 1, irq_out, s_axi_awready, s_axi_wready;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [N-1:0] req = '0, hw_trigger, pending_masked_bits;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [127:0] raw_e = '0, en_e = '0;
    int fails = 0, total_checks = 0;
    always #50 aclk = ~aclk;
    sieb_src_model #(.NUM_IRQ(N)) src (.aclk(aclk), .req(req), .hw_trigger(hw_trigger));
    sieb_bank #(.NUM_IRQ(N)) DUT (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf), .*);
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task ck(input logic [127:0] g, input logic [127:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    // one register access; answers are taken at the edge that shows valid and ready
    task bus(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        logic ta, tw, tr, dn;
        dn = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{!rd}};
        {s_axi_arvalid, s_axi_rready} <= {2{rd}};
        for (int n = 0; n < 20 && !dn; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            dn = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
            if (dn && rd) ck(s_axi_rdata, e);
            if (dn) ck(rd ? s_axi_rresp : s_axi_bresp, a > 8'h44 ? `SIEB_RESP_SLVERR : OK);
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tr) s_axi_arvalid <= 0;
            if (dn) {s_axi_bready, s_axi_rready} <= 2'b00;
        end
        if (!dn) begin
            fails++;
            conclude;
        end
        @(negedge aclk);
    endtask
    task check_all;
        logic [31:0] e;
        for (int i = 0; i < 16; i++) begin
            e = i < 8 ? raw_e[32 * (i % 4) +: 32] : en_e[32 * (i % 4) +: 32];
            bus(1, `SIEB_RAW_SET_G1 + 8'(4 * i), 0, e);
        end
        ck(pending_masked_bits, N'(raw_e & en_e));
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        check_all;
        ck(irq_out, 0);
        bus(0, 8'h80, 1, 0);
        bus(1, 8'h80, 0, 0);
        for (int k = 0; k < 4; k++) begin
            raw_e[32 * k +: 32] = k == 3 ? 32'h3 : 32'hc000_0003;
            en_e[32 * k +: 32] = k == 3 ? 32'h1 : 32'h8000_0001;
            bus(0, `SIEB_RAW_SET_G1 + 8'(4 * k), 32'hc000_0003, 0);
            bus(0, `SIEB_ENA_SET_G1 + 8'(4 * k), 32'h8000_0001, 0);
        end
        check_all;
        for (int k = 0; k < 4; k++) begin
            en_e[32 * k + 31] = 0;
            raw_e[32 * k] = 0;
            bus(0, `SIEB_ENA_CLR_G1 + 8'(4 * k), 32'h8000_0000, 0);
            bus(0, `SIEB_STS_CLR_G1 + 8'(4 * k), 32'h1, 0);
        end
        check_all;
        // events: enabled pending, unmapped write, unmapped read
        bus(1, `SIEB_IRQ_STAT, 0, 32'he);
        ck(irq_out, 0);
        bus(0, `SIEB_IRQ_MASK, 32'h2, 0);
        ck(irq_out, 1);
        bus(0, `SIEB_IRQ_STAT, 32'he, 0);
        ck(irq_out, 0);
        req <= N'(1) << 32;
        repeat (3) @(posedge aclk);
        bus(0, `SIEB_STS_CLR_G2, 32'h1, 0);
        raw_e[32] = 1;
        ck(pending_masked_bits, N'(raw_e & en_e));
        ck(irq_out, 1);
        // a disabled source fires while the serviced one is cleared
        req <= N'(1) << 34;
        repeat (3) @(posedge aclk);
        raw_e[34] = 1;
        raw_e[32] = 0;
        bus(0, `SIEB_STS_CLR_G2, 32'h1, 0);
        bus(0, `SIEB_IRQ_STAT, 32'hf, 0);
        ck(irq_out, 0);
        // the still-high trigger sets its event again over the clear
        bus(1, `SIEB_IRQ_STAT, 0, 32'h1);
        check_all;
        // a read offered while frozen must wait until the clock enable returns
        clk_en <= 0;
        fork
            bus(1, `SIEB_RAW_SET_G2, 0, raw_e[32 +: 32]);
            begin
                repeat (3) @(posedge aclk);
                clk_en <= 1;
            end
        join
        req <= '0;
        clk_en <= 0;
        repeat (3) @(posedge aclk);
        {clk_en, aresetn} <= 2'b10;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        {raw_e, en_e} = '0;
        check_all;
        ck(irq_out, 0);
        conclude;
    end
endmodule
